// file: design/ttx_map.vh
/*
 * Constants for the transmit write and flow-control block: queue geometry,
 * bus field positions and the idle character codes.
 * Assumes inclusion by bare name from design files compiled in the same run.
 */
`ifndef TTX_MAP_VH
`define TTX_MAP_VH

// Queue geometry
`define TTX_DEPTH 256
`define TTX_ADDR_W 8
`define TTX_DATA_W 12
// Writes still accepted after the full flag first rises
`define TTX_FULL_MARGIN 8

// Cell start marker position on the parallel bus (encoder enabled)
`define TTX_SOC_BIT 11

// Idle fill: coded C5.0 special, and its two raw 10-bit disparity forms
`define TTX_IDLE_CODED 12'h0BC
`define TTX_IDLE_RAW_NEG 12'h0FA
`define TTX_IDLE_RAW_POS 12'h305

// Synchroniser depth for pin inputs
`define TTX_SYNC_STAGES 2

`endif

// file: design/ttx_sync.v
/*
 * Two-flop synchroniser for a vector of independent pin levels.
 * Assumes each bit is a slow level or a clock far below the sampling clock;
 * bits are not coherent with each other across a change.
 */
`timescale 1ns/1ps
`default_nettype none

module ttx_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage; reset to the idle pin levels
  // so an active-low control never looks asserted while the chain refills
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

`default_nettype wire

// file: design/ttx_top.v
/*
 * Transmit write path and flow control of a serial link transceiver: the
 * parallel write port, the transmit queue, stop-on-cell gating, idle fill
 * and the full flag with its polarity and drive rules.
 * Assumes all pins, including the write clock and reference clock, are
 * asynchronous to I_CLOCK and at least four times slower; one character
 * leaves per reference clock rising edge through O_TX_CHAR and its strobe.
 */
// Overview of operation
// R1: Enable and full polarity follow timing select
// R2: Queue stores a character per write clock
// R3: Enable off: drain queue, then send idle
// R4: Bypass: send bus when enabled, else sync
// R5: Stop: run to next cell start, halt
// R6: Stop pulse while halted sends one cell
// R7: Stop ignored while queue bypassed
// R8: Coder bypass: stop suspends reads, raw idles
// R9: Queue inputs sampled on write clock edge
// R10: Full flag driven only on address match
// R11: Full flag leaves eight more writes accepted
// R12: Bypass full flag toggles at character rate; code holds it still with range select low and speed band select high
// R13: Host marks each packet start with marker
// R14: Idle characters fill every empty character slot
`timescale 1ns/1ps
`default_nettype none
`include "ttx_map.vh"

module ttx_top #(
  parameter DEPTH = `TTX_DEPTH,
  parameter ADDR_W = `TTX_ADDR_W,
  parameter DATA_W = `TTX_DATA_W,
  parameter MARGIN = `TTX_FULL_MARGIN
) (
  input wire I_CLOCK,
  input wire I_RST_B,
  input wire I_TX_QUEUE_WRITE_CLOCK,
  input wire I_REFERENCE_CLOCK_IN,
  input wire I_TX_WRITE_ENABLE,
  input wire [DATA_W-1:0] I_TX_PARALLEL_BUS,
  input wire I_CASCADE_TIMING_SELECT,
  input wire I_TX_QUEUE_BYPASS_N,
  input wire I_CODER_BYPASS_N,
  input wire I_TX_PAUSE_N,
  input wire I_TX_STOP_ON_CELL_N,
  input wire I_ADDRESS_MATCH_N,
  input wire I_RATE_RANGE_SELECT,
  input wire I_SPEED_BAND_SELECT,
  output reg [DATA_W-1:0] O_TX_CHAR,
  output reg O_TX_CHAR_K,
  output reg O_TX_CHAR_STB,
  output reg O_TX_IDLE,
  output reg O_TX_HALTED,
  output reg O_TX_QUEUE_FULL_FLAG,
  output reg O_TX_QUEUE_FULL_FLAG_OE
);

  localparam SW = DATA_W + 11;
  localparam [31:0] FULL_AT_I = DEPTH - MARGIN;
  localparam [31:0] CAP_I = DEPTH;
  localparam [ADDR_W:0] FULL_AT = FULL_AT_I[ADDR_W:0];
  localparam [ADDR_W:0] CAP = CAP_I[ADDR_W:0];
  // Idle levels: clocks low, enable high, active-low controls released
  localparam [SW-1:0] PIN_IDLE = {11'h17C, {DATA_W{1'b0}}};

  // Timing select picks the active level of enable and full flag [R1]
  function pol;
    input lvl;
    input cascade;
    begin
      pol = cascade ? lvl : ~lvl;
    end
  endfunction

  // Every pin passes the synchroniser before any logic reads it
  wire [SW-1:0] pins_raw;
  wire [SW-1:0] pins_s;

  assign pins_raw = {I_TX_QUEUE_WRITE_CLOCK, I_REFERENCE_CLOCK_IN, I_TX_WRITE_ENABLE,
                     I_CASCADE_TIMING_SELECT, I_TX_QUEUE_BYPASS_N, I_CODER_BYPASS_N,
                     I_TX_PAUSE_N, I_TX_STOP_ON_CELL_N, I_ADDRESS_MATCH_N,
                     I_RATE_RANGE_SELECT, I_SPEED_BAND_SELECT, I_TX_PARALLEL_BUS};

  ttx_sync #(
    .WIDTH(SW),
    .RST_VAL(PIN_IDLE)
  ) u_sync (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  wire wclk_s = pins_s[SW-1];
  wire rclk_s = pins_s[SW-2];
  wire wen_s = pins_s[SW-3];
  wire cascade_s = pins_s[SW-4];
  wire queue_on = pins_s[SW-5];
  wire coder_on = pins_s[SW-6];
  wire pause_n_s = pins_s[SW-7];
  wire stop_n_s = pins_s[SW-8];
  wire match_n_s = pins_s[SW-9];
  wire range_s = pins_s[SW-10];
  wire speed_s = pins_s[SW-11];
  wire [DATA_W-1:0] bus_s = pins_s[DATA_W-1:0];

  // Edge finders work on synchronised copies only
  reg wclk_d_r;
  reg rclk_d_r;
  wire wr_edge = wclk_s & ~wclk_d_r;
  wire char_edge = rclk_s & ~rclk_d_r;

  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      wclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end
    else
    begin
      wclk_d_r <= wclk_s;
      rclk_d_r <= rclk_s;
    end
  end

  // Queue storage and pointers
  reg [DATA_W-1:0] mem_r [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr_r;
  reg [ADDR_W-1:0] rd_ptr_r;
  reg [ADDR_W:0] count_r;
  reg [ADDR_W:0] count_nxt;
  reg halted_r;
  reg pass_soc_r;
  reg disp_r;
  reg toggle_r;

  wire we_act = pol(wen_s, cascade_s);                       // [R1]
  wire stop_act = ~stop_n_s;
  wire pause_act = ~pause_n_s;
  wire have = (count_r != {(ADDR_W+1){1'b0}});
  wire [DATA_W-1:0] head = mem_r[rd_ptr_r];
  wire head_soc = head[`TTX_SOC_BIT];

  // Writes land only on the write clock edge, and only while room remains [R2] [R9] [R11]
  wire do_wr = queue_on & wr_edge & we_act & (count_r != CAP);

  // Stop with the coder on halts in front of a cell start unless one cell was released [R5] [R6]
  wire cell_hold = stop_act & head_soc & ~pass_soc_r;
  // Coder bypassed: bit 11 is data, the stop acts at once as a pause [R8]
  wire hold = coder_on ? (pause_act | cell_hold) : stop_act;
  wire do_rd = queue_on & char_edge & have & ~hold;          // [R3] [R7]

  // Pointer and occupancy update
  always @*
  begin
    count_nxt = count_r;
    if (do_wr && !do_rd)
      count_nxt = count_r + {{ADDR_W{1'b0}}, 1'b1};
    else if (do_rd && !do_wr)
      count_nxt = count_r - {{ADDR_W{1'b0}}, 1'b1};
  end

  // Storage has no reset; occupancy alone says what is valid
  always @(posedge I_CLOCK)
  begin
    if (do_wr)
      mem_r[wr_ptr_r] <= bus_s;                              // [R2]
  end

  // Bypassing the queue empties it so stale data never follows a mode change
  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      wr_ptr_r <= {ADDR_W{1'b0}};
      rd_ptr_r <= {ADDR_W{1'b0}};
      count_r <= {(ADDR_W+1){1'b0}};
    end
    else if (!queue_on)
    begin
      wr_ptr_r <= {ADDR_W{1'b0}};
      rd_ptr_r <= {ADDR_W{1'b0}};
      count_r <= {(ADDR_W+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_r <= wr_ptr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
      if (do_rd)
        rd_ptr_r <= rd_ptr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
      count_r <= count_nxt;
    end
  end

  // Cell stop bookkeeping; only meaningful with queue and coder both on [R7]
  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      halted_r <= 1'b0;
      pass_soc_r <= 1'b0;
    end
    else if (!queue_on || !coder_on)
    begin
      halted_r <= 1'b0;
      pass_soc_r <= 1'b0;
    end
    else
    begin
      // Release seen while halted: the waiting cell start may go once [R6]
      // A cell start leaving in the release cycle itself uses up the pass
      if (do_rd && head_soc)
        pass_soc_r <= 1'b0;
      else if (halted_r && !stop_act)
        pass_soc_r <= 1'b1;
      // Halt is entered at a character slot blocked by a cell start [R5]
      if (char_edge && have && cell_hold)
        halted_r <= 1'b1;
      else if (!stop_act)
        halted_r <= 1'b0;
    end
  end

  // Character output, one per reference clock edge
  reg [DATA_W-1:0] char_nxt;
  reg k_nxt;
  reg idle_nxt;

  always @*
  begin
    char_nxt = `TTX_IDLE_CODED;
    k_nxt = 1'b1;
    idle_nxt = 1'b1;
    if (queue_on && do_rd)
    begin
      char_nxt = head;                                       // [R3]
      k_nxt = 1'b0;
      idle_nxt = 1'b0;
    end
    else if (!queue_on && we_act)
    begin
      char_nxt = bus_s;                                      // [R4]
      k_nxt = 1'b0;
      idle_nxt = 1'b0;
    end
    else if (!coder_on)
    begin
      // Raw fill alternates disparity so the line stays balanced [R8]
      char_nxt = disp_r ? `TTX_IDLE_RAW_POS : `TTX_IDLE_RAW_NEG;
      k_nxt = 1'b0;
    end
  end

  // Every slot yields a character; gaps become idle fill [R14] [R4]
  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_TX_CHAR <= `TTX_IDLE_CODED;
      O_TX_CHAR_K <= 1'b1;
      O_TX_IDLE <= 1'b1;
      O_TX_CHAR_STB <= 1'b0;
      disp_r <= 1'b0;
    end
    else
    begin
      O_TX_CHAR_STB <= char_edge;                            // [R14]
      if (char_edge)
      begin
        O_TX_CHAR <= char_nxt;
        O_TX_CHAR_K <= k_nxt;
        O_TX_IDLE <= idle_nxt;
        if (idle_nxt && !coder_on)
          disp_r <= ~disp_r;
      end
    end
  end

  // Full level: queue near capacity, or character-rate toggle when bypassed with range select high or speed band select low
  wire rate_mark = range_s | ~speed_s;
  wire full_lvl = queue_on ? (count_nxt >= FULL_AT) : (rate_mark & toggle_r); // [R11]

  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      toggle_r <= 1'b0;
    else if (queue_on || !rate_mark)
      toggle_r <= 1'b0;
    else if (char_edge)
      toggle_r <= ~toggle_r;                                 // [R12]
  end

  // Flag pin: polarity by timing select, driven only while addressed
  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_TX_QUEUE_FULL_FLAG <= 1'b0;
      O_TX_QUEUE_FULL_FLAG_OE <= 1'b0;
      O_TX_HALTED <= 1'b0;
    end
    else
    begin
      O_TX_QUEUE_FULL_FLAG <= pol(full_lvl, cascade_s);      // [R1]
      O_TX_QUEUE_FULL_FLAG_OE <= ~match_n_s;                 // [R10]
      O_TX_HALTED <= halted_r;
    end
  end

endmodule

`default_nettype wire

// file: test/ttx_top_properties.sv
/* Checker for the transmit write block, bound to ttx_top.
   Assumes pins move far slower than the 200 MHz sampling clock. */
`timescale 1ns/1ps
`default_nettype none
module ttx_top_chk #(
  parameter DATA_W = 12
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_TX_QUEUE_WRITE_CLOCK,
  input wire logic I_REFERENCE_CLOCK_IN,
  input wire logic I_TX_WRITE_ENABLE,
  input wire logic [DATA_W-1:0] I_TX_PARALLEL_BUS,
  input wire logic I_CASCADE_TIMING_SELECT,
  input wire logic I_TX_QUEUE_BYPASS_N,
  input wire logic I_CODER_BYPASS_N,
  input wire logic I_TX_PAUSE_N,
  input wire logic I_TX_STOP_ON_CELL_N,
  input wire logic I_ADDRESS_MATCH_N,
  input wire logic I_RATE_RANGE_SELECT,
  input wire logic I_SPEED_BAND_SELECT,
  input wire logic [DATA_W-1:0] O_TX_CHAR,
  input wire logic O_TX_CHAR_K,
  input wire logic O_TX_CHAR_STB,
  input wire logic O_TX_IDLE,
  input wire logic O_TX_HALTED,
  input wire logic O_TX_QUEUE_FULL_FLAG,
  input wire logic O_TX_QUEUE_FULL_FLAG_OE
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);
  // Windows of five or six cycles cover the pin synchroniser and the slot register
  wire logic byp = !I_TX_QUEUE_BYPASS_N;
  wire logic act = I_TX_WRITE_ENABLE == I_CASCADE_TIMING_SELECT;
  oe_on_a: assert property (!I_ADDRESS_MATCH_N [*5] |-> O_TX_QUEUE_FULL_FLAG_OE) else $error("flag undriven");
  oe_off_a: assert property (I_ADDRESS_MATCH_N [*5] |-> !O_TX_QUEUE_FULL_FLAG_OE) else $error("flag driven");
  byp_send_a: assert property ((byp && act && $stable(I_TX_PARALLEL_BUS)) [*6] ##0 O_TX_CHAR_STB
    |-> O_TX_CHAR == I_TX_PARALLEL_BUS && !O_TX_CHAR_K) else $error("bus not sent");
  byp_sync_a: assert property ((byp && !act && I_CODER_BYPASS_N) [*6] ##0 O_TX_CHAR_STB
    |-> O_TX_CHAR == 12'h0BC && O_TX_CHAR_K)
    else $error("no sync fill");
  byp_nohalt_a: assert property (byp [*6] |-> !O_TX_HALTED) else $error("halt in bypass");
  halt_fill_a: assert property (O_TX_HALTED && O_TX_CHAR_STB |-> O_TX_IDLE) else $error("sent while halted");
  raw_stop_a: assert property ((!byp && !I_CODER_BYPASS_N && !I_TX_STOP_ON_CELL_N) [*6] ##0 O_TX_CHAR_STB
    |-> O_TX_IDLE && (O_TX_CHAR == 12'h0FA || O_TX_CHAR == 12'h305)) else $error("raw stop failed");
  rate_off_a: assert property ((byp && !I_RATE_RANGE_SELECT && I_SPEED_BAND_SELECT) [*6]
    |-> $stable(O_TX_QUEUE_FULL_FLAG)) else $error("flag moved");
endmodule
bind ttx_top ttx_top_chk #(.DATA_W(DATA_W)) chk (.I_CLOCK, .I_RST_B, .I_TX_QUEUE_WRITE_CLOCK,
  .I_REFERENCE_CLOCK_IN, .I_TX_WRITE_ENABLE, .I_TX_PARALLEL_BUS, .I_CASCADE_TIMING_SELECT,
  .I_TX_QUEUE_BYPASS_N, .I_CODER_BYPASS_N, .I_TX_PAUSE_N, .I_TX_STOP_ON_CELL_N, .I_ADDRESS_MATCH_N,
  .I_RATE_RANGE_SELECT, .I_SPEED_BAND_SELECT, .O_TX_CHAR, .O_TX_CHAR_K, .O_TX_CHAR_STB, .O_TX_IDLE,
  .O_TX_HALTED, .O_TX_QUEUE_FULL_FLAG, .O_TX_QUEUE_FULL_FLAG_OE);
`default_nettype wire

// file: test/ttx_host_model.sv
/* Host writer on the parallel port: write clock, enable and bus.
   Assumes the bench calls its tasks and owns the mode pins. */
`timescale 1ns/1ps
`default_nettype none
module ttx_host_model (
  input wire logic i_clk,
  input wire logic i_cascade,
  output logic o_wclk,
  output wire logic o_en,
  output logic [11:0] o_bus
);
  logic act = 1'b0;
  initial
  begin
    o_wclk = 1'b0;
    o_bus = 12'h000;
  end
  // Enable level follows the timing select
  assign o_en = act ? i_cascade : ~i_cascade;
  task automatic hold(input logic [11:0] d);
    act = 1'b1;
    o_bus = d;
  endtask
  // A released bus must not keep showing its last value
  task automatic drop();
    act = 1'b0;
    o_bus = ~o_bus;
  endtask
  // Bus held four cycles each side of the write clock rise
  task automatic put(input logic [11:0] d);
    @(posedge i_clk) #1;
    hold(d);
    repeat (4) @(posedge i_clk);
    #1 o_wclk = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 o_wclk = 1'b0;
    drop();
  endtask
endmodule
`default_nettype wire

// file: test/tx_fifo_host_write_flow_control_bench.sv
/* Self-checking bench for ttx_top with a host writer model.
   Assumes a 200 MHz system clock and a free 8 MHz reference clock. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; $display("unexpected %0t %h %h", $time, a, b); end end
module tx_fifo_host_write_flow_control_bench;
  logic clk = 1'b0, rclk = 1'b0, rst_b = 1'b0;
  logic cas, byp_n, cod_n, pause_n, stop_n, am_n, rng, spd;
  wire logic wclk, en, stb, kc, idle, halt, flag, oe;
  wire logic [11:0] bus, chr;
  int failures = 0, n_compared = 0, i;
  logic [11:0] a;
  initial
    forever #2.5 clk = ~clk;
  // Reference clock kept out of phase with the system clock
  initial
  begin
    #7.3;
    forever #62.5 rclk = ~rclk;
  end
  ttx_host_model host (.i_clk(clk), .i_cascade(cas), .o_wclk(wclk), .o_en(en), .o_bus(bus));
  ttx_top dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_TX_QUEUE_WRITE_CLOCK(wclk), .I_REFERENCE_CLOCK_IN(rclk),
    .I_TX_WRITE_ENABLE(en), .I_TX_PARALLEL_BUS(bus), .I_CASCADE_TIMING_SELECT(cas), .I_TX_QUEUE_BYPASS_N(byp_n),
    .I_CODER_BYPASS_N(cod_n), .I_TX_PAUSE_N(pause_n), .I_TX_STOP_ON_CELL_N(stop_n), .I_ADDRESS_MATCH_N(am_n),
    .I_RATE_RANGE_SELECT(rng), .I_SPEED_BAND_SELECT(spd), .O_TX_CHAR(chr), .O_TX_CHAR_K(kc), .O_TX_CHAR_STB(stb),
    .O_TX_IDLE(idle), .O_TX_HALTED(halt), .O_TX_QUEUE_FULL_FLAG(flag), .O_TX_QUEUE_FULL_FLAG_OE(oe));
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Next character slot, sampled once the strobe has settled
  task automatic slot();
    int k;
    k = 0;
    do
    begin
      @(posedge clk) #1;
      k++;
    end
    while (stb !== 1'b1 && k < 400);
    if (k >= 400)
      failures++;
  endtask
  // Skip fill slots up to the next data character
  task automatic data(input logic [11:0] d);
    int n;
    n = 0;
    slot();
    while (idle !== 1'b0 && n < 40)
    begin
      slot();
      n++;
    end
    `CHK(chr, d)
  endtask
  task automatic t_bypass();
    byp_n = 1'b0;
    stop_n = 1'b0;
    am_n = 1'b0;
    host.hold(12'h1A5);
    repeat (2) slot();
    `CHK(chr, 12'h1A5)
    `CHK(halt, 1'b0)
    `CHK(oe, 1'b1)
    rng = 1'b1;
    repeat (2) slot();
    a[0] = flag;
    slot();
    `CHK(flag, ~a[0])
    rng = 1'b0;
    spd = 1'b0;
    slot();
    a[0] = flag;
    slot();
    `CHK(flag, ~a[0])
    spd = 1'b1;
    host.drop();
    am_n = 1'b1;
    repeat (2) slot();
    `CHK(chr, 12'h0BC)
    `CHK(oe, 1'b0)
    stop_n = 1'b1;
    byp_n = 1'b1;
    $display("t_bypass done");
  endtask
  task automatic t_queue();
    cas = 1'b0;
    pause_n = 1'b0;
    for (i = 1; i < 4; i++)
      host.put(12'h011 * i[11:0]);
    `CHK(flag, 1'b1)
    pause_n = 1'b1;
    for (i = 1; i < 4; i++)
      data(12'h011 * i[11:0]);
    slot();
    `CHK(chr, 12'h0BC)
    $display("t_queue done");
  endtask
  // Fill while paused, then drain: the margin writes must survive
  task automatic t_full();
    cas = 1'b1;
    am_n = 1'b0;
    pause_n = 1'b0;
    for (i = 0; i < 247; i++)
      host.put(i[11:0]);
    `CHK(flag, 1'b0)
    host.put(12'h0F7);
    repeat (2) @(posedge clk);
    `CHK(flag, 1'b1)
    for (i = 248; i < 256; i++)
      host.put(i[11:0]);
    host.put(12'h1FF);
    pause_n = 1'b1;
    for (i = 0; i < 256; i++)
      data(i[11:0]);
    slot();
    `CHK(idle, 1'b1)
    `CHK(flag, 1'b0)
    am_n = 1'b1;
    $display("t_full done");
  endtask
  task automatic t_cell();
    stop_n = 1'b0;
    host.put(12'h801);
    host.put(12'h002);
    host.put(12'h803);
    host.put(12'h004);
    repeat (3) slot();
    `CHK({halt, idle}, 2'b11)
    stop_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 stop_n = 1'b0;
    data(12'h801);
    data(12'h002);
    repeat (2) slot();
    `CHK({halt, idle}, 2'b11)
    stop_n = 1'b1;
    data(12'h803);
    data(12'h004);
    $display("t_cell done");
  endtask
  task automatic t_raw();
    cod_n = 1'b0;
    stop_n = 1'b0;
    host.put(12'h805);
    host.put(12'h006);
    slot();
    a = chr;
    slot();
    `CHK(a ^ chr, 12'h3FF)
    stop_n = 1'b1;
    data(12'h805);
    data(12'h006);
    $display("t_raw done");
  endtask
  initial
  begin
    #300000;
    failures++;
    wrap_up();
  end
  initial
  begin
    cas = 1'b1;
    byp_n = 1'b1;
    cod_n = 1'b1;
    pause_n = 1'b1;
    stop_n = 1'b1;
    am_n = 1'b1;
    rng = 1'b0;
    spd = 1'b1;
    repeat (5) @(posedge clk);
    `CHK({chr, kc, idle, halt, flag, oe}, {12'h0BC, 5'h18})
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk) #1;
    t_bypass();
    t_queue();
    t_full();
    t_cell();
    t_raw();
    wrap_up();
  end
endmodule
`default_nettype wire
